// File: rtl/apso_cfg.svh
`ifndef APSO_CFG_SVH
`define APSO_CFG_SVH

// position word layout
`define APSO_WORD_W          13
`define APSO_COARSE_W        11
`define APSO_FRAME_BITS      4'hd
`define APSO_CNT_W           4

// register byte offsets on the 8-bit address port
`define APSO_ADDR_CTRL       8'h00
`define APSO_ADDR_STATUS     8'h04
`define APSO_ADDR_MASK       8'h08
`define APSO_ADDR_POSITION   8'h0c
`define APSO_ADDR_PINS       8'h10

// control register fields
`define APSO_CTRL_OVERRIDE   0
`define APSO_CTRL_CORRECT    1
`define APSO_CTRL_INVERT     2
`define APSO_CTRL_W          3
`define APSO_CTRL_RESET      3'h0

// status and mask fields
`define APSO_ST_FRAME_DONE   0
`define APSO_ST_LOADED       1
`define APSO_ST_LIGHT_ERR    2
`define APSO_ST_W            3
`define APSO_STATUS_RESET    3'h0
`define APSO_MASK_RESET      3'h0

// positions inside the synchronised pin vector
`define APSO_PIN_COARSE_LO   0
`define APSO_PIN_COARSE_HI   10
`define APSO_PIN_SINE        11
`define APSO_PIN_COSINE      12
`define APSO_PIN_INTERP      13
`define APSO_PIN_CORRECT     14
`define APSO_PIN_INVERT      15
`define APSO_PIN_SEL         16
`define APSO_PIN_SIN         17
`define APSO_PIN_SCLK        18
`define APSO_PIN_LIGHT       19
`define APSO_PIN_W           20
// synchroniser reset value: select, chain input and shift clock at idle high
`define APSO_PIN_RESET       20'h70000

`endif

// File: rtl/apso_pkg.sv
`include "apso_cfg.svh"

package apso_pkg;

	// shift register mode as chosen by the load/shift select pin
	typedef enum logic [0:0]
	{
		APSO_MODE_SHIFT = 1'b0,
		APSO_MODE_LOAD  = 1'b1
	} apso_mode_t;

	// complete state of the block
	typedef struct packed
	{
		logic [`APSO_PIN_W-1:0]   pin_s1;
		logic [`APSO_PIN_W-1:0]   pin_s2;
		logic                     sclk_prev;
		apso_mode_t               mode;
		logic [`APSO_WORD_W-1:0]  shreg;
		logic [`APSO_CNT_W-1:0]   bit_cnt;
		logic [`APSO_CTRL_W-1:0]  ctrl;
		logic [`APSO_ST_W-1:0]    status;
		logic [`APSO_ST_W-1:0]    mask;
		logic [`APSO_WORD_W-1:0]  pos_snap;
		logic                     light_prev;
		logic                     light_error;
		logic [31:0]              rdata;
	} apso_state_t;

endpackage

// File: rtl/apso_top.sv
// Contract
// - the position word leaves the serial output most significant bit first, top coarse bit leading.
// - with direction invert high the most significant bit of the word is inverted; with override set the code uses the ctrl invert bit instead.
// - the code counts up clockwise and down counter-clockwise, both reversed when direction invert is high.
// - the serial input enters the shift register at the far end and moves toward the serial output.
// - load/shift select at 1 means load mode and at 0 means shift mode, chosen by the controller.
// - in load mode the serial output shows the most significant position bit.
// - in shift mode every rising shift clock edge advances the register by one bit.
// - the shift clock may run up to 16 MHz and the controller keeps below that rate.
// - the gray correction input enables correction at 1 and disables it at 0; with override set the code uses the ctrl correct bit instead.
// - correction touches only the upper twelve bits and leaves the interpolated bit alone.
// - correction aligns the coarse switching points to the digitised sine and cosine tracks.
// - sine track forms bit one, the interpolator the lowest bit, merged with eleven coarse bits into 13 bits.
// - the light error output is 1 for a light source fault and 0 otherwise.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "apso_cfg.svh"

module apso_top
	import apso_pkg::*;
(
	input  wire logic                        clock,             // 50 MHz system clock
	input  wire logic                        rst,               // async reset, active high
	input  wire logic [`APSO_COARSE_W-1:0]   coarse_track,      // digitised coarse gray tracks, top is msb
	input  wire logic                        sine_track_bit,    // digitised sine track
	input  wire logic                        cosine_track_bit,  // digitised cosine track
	input  wire logic                        interp_bit,        // interpolated lowest bit
	input  wire logic                        gray_correct_en,   // 1 enables gray correction
	input  wire logic                        direction_invert,  // 1 inverts the msb
	input  wire logic                        load_shift_sel,    // 1 load, 0 shift
	input  wire logic                        serial_in,         // chain or ring input
	input  wire logic                        shift_clk,         // controller shift clock
	input  wire logic                        light_fault,       // light monitor comparator
	input  wire logic [7:0]                  addr,              // register byte address
	input  wire logic [31:0]                 wdata,             // register write data
	input  wire logic                        wr,                // write strobe
	input  wire logic                        rd,                // read strobe
	output logic      [31:0]                 rdata,             // read data, cycle after rd
	output logic                             serial_out,        // shift register output
	output logic                             light_error,       // 1 while light fault seen
	output logic                             irq                // level interrupt
);

	apso_state_t st;
	apso_state_t next_st;

	// every pin crosses two flops before use; the tracks are synced bit by bit,
	// so a word taken right on a track edge may mix old and new bits
	// raw pins gathered for the synchroniser
	logic [`APSO_PIN_W-1:0] pin_raw;

	assign pin_raw = {light_fault, shift_clk, serial_in, load_shift_sel, direction_invert,
		gray_correct_en, interp_bit, cosine_track_bit, sine_track_bit, coarse_track};

	// synchronised views of the pins
	logic [`APSO_COARSE_W-1:0] coarse_s;
	logic                      sine_s;
	logic                      cosine_s;
	logic                      interp_s;
	logic                      correct_pin_s;
	logic                      invert_pin_s;
	logic                      sel_s;
	logic                      sin_s;
	logic                      sclk_s;
	logic                      light_s;

	assign coarse_s      = st.pin_s2[`APSO_PIN_COARSE_HI:`APSO_PIN_COARSE_LO];
	assign sine_s        = st.pin_s2[`APSO_PIN_SINE];
	assign cosine_s      = st.pin_s2[`APSO_PIN_COSINE];
	assign interp_s      = st.pin_s2[`APSO_PIN_INTERP];
	assign correct_pin_s = st.pin_s2[`APSO_PIN_CORRECT];
	assign invert_pin_s  = st.pin_s2[`APSO_PIN_INVERT];
	assign sel_s         = st.pin_s2[`APSO_PIN_SEL];
	assign sin_s         = st.pin_s2[`APSO_PIN_SIN];
	assign sclk_s        = st.pin_s2[`APSO_PIN_SCLK];
	assign light_s       = st.pin_s2[`APSO_PIN_LIGHT];

	// effective settings, software may take them over from the pins
	logic correct_on;
	logic invert_on;

	assign correct_on = st.ctrl[`APSO_CTRL_OVERRIDE] ? st.ctrl[`APSO_CTRL_CORRECT] : correct_pin_s;
	assign invert_on  = st.ctrl[`APSO_CTRL_OVERRIDE] ? st.ctrl[`APSO_CTRL_INVERT] : invert_pin_s;

	// rising edge of the sampled shift clock
	// each half period of the link clock must span more than one system clock,
	// else a rise is lost in the synchroniser; the link therefore runs well below
	// the rate of a register clocked by the pin itself
	logic sclk_rise;

	assign sclk_rise = sclk_s & ~st.sclk_prev;

	// position word assembly
	logic [`APSO_COARSE_W-1:0] coarse_bin;
	logic [`APSO_COARSE_W-1:0] coarse_fix;
	logic                      fine_b0;
	logic [11:0]               bin12;
	logic [11:0]               gray12;
	logic [`APSO_WORD_W-1:0]   pos_word;

	always_comb
	begin
		coarse_bin = '0;
		coarse_fix = '0;
		fine_b0    = 1'b0;
		bin12      = '0;
		gray12     = '0;
		pos_word   = '0;
		// coarse gray to binary, msb first
		coarse_bin[`APSO_COARSE_W-1] = coarse_s[`APSO_COARSE_W-1];
		for (int i = `APSO_COARSE_W-2; i >= 0; i--)
		begin
			coarse_bin[i] = coarse_bin[i+1] ^ coarse_s[i];
		end
		// quadrant low bit from sine and cosine
		fine_b0    = sine_s ^ cosine_s;
		coarse_fix = coarse_bin;
		// align coarse edges
		// cosine equals the coarse binary lsb, a mismatch means the coarse edge is early or late
		// the fine bit tells which half of the coarse step the shaft is in, so an
		// early or late coarse edge is pulled back or pushed forward by one step
		if (correct_on && (coarse_bin[0] != cosine_s))
		begin
			if (fine_b0)
			begin
				coarse_fix = coarse_bin - `APSO_COARSE_W'(1);
			end
			else
			begin
				coarse_fix = coarse_bin + `APSO_COARSE_W'(1);
			end
		end
		if (correct_on)
		begin
			bin12  = {coarse_fix, fine_b0};
			gray12 = bin12 ^ {1'b0, bin12[11:1]};
		end
		else
		begin
			// without correction the gray tracks pass straight through
			// sine track merged
			gray12 = {coarse_s, sine_s};
		end
		pos_word = {gray12, interp_s};
		// flipping only the msb mirrors the code, so the count runs the other way
		// msb inversion
		pos_word[`APSO_WORD_W-1] = pos_word[`APSO_WORD_W-1] ^ invert_on;
	end

	// register map, all fields in the low bits of the 32-bit word
	// ctrl: override, correct and invert, used instead of the pins when override is set
	// status: frame done, position loaded, light error rise; written ones clear
	// mask: same layout as status, gates the interrupt
	// position: word captured as the register leaves load mode
	// pins: synchronised pin vector, for bring-up
	// write decode
	logic wr_ctrl;
	logic wr_status;
	logic wr_mask;

	assign wr_ctrl   = wr && (addr == `APSO_ADDR_CTRL);
	assign wr_status = wr && (addr == `APSO_ADDR_STATUS);
	assign wr_mask   = wr && (addr == `APSO_ADDR_MASK);

	// events seen this cycle
	// one bit per status field, high for a single cycle
	logic [`APSO_ST_W-1:0] ev;
	logic                  enter_shift;

	assign enter_shift = (st.mode == APSO_MODE_LOAD) && !sel_s;

	// next state
	always_comb
	begin
		next_st = st;
		ev      = '0;
		// two-stage pin synchroniser
		// the first flop feeds only the second
		next_st.pin_s1    = pin_raw;
		next_st.pin_s2    = st.pin_s1;
		next_st.sclk_prev = sclk_s;
		next_st.mode = sel_s ? APSO_MODE_LOAD : APSO_MODE_SHIFT;
		unique case (st.mode)
			APSO_MODE_LOAD:
			begin
				// reload every cycle so the word tracks the shaft until shifting starts
				// msb shown in load
				next_st.shreg   = pos_word;
				next_st.bit_cnt = '0;
				// snapshot the word loaded one cycle before the word whose bits go out
				if (enter_shift)
				begin
					next_st.pos_snap           = st.shreg;
					ev[`APSO_ST_LOADED]        = 1'b1;
				end
			end
			APSO_MODE_SHIFT:
			begin
				if (sel_s)
				begin
					next_st.shreg   = pos_word;
					next_st.bit_cnt = '0;
				end
				else if (sclk_rise)
				begin
					// the chained input enters at the far end on each detected rise
					// one bit per edge
					next_st.shreg = {st.shreg[`APSO_WORD_W-2:0], sin_s};
					// the count stops at thirteen, so frame done fires once per frame
					if (st.bit_cnt != `APSO_FRAME_BITS)
					begin
						next_st.bit_cnt = st.bit_cnt + `APSO_CNT_W'(1);
					end
					if (st.bit_cnt == (`APSO_FRAME_BITS - `APSO_CNT_W'(1)))
					begin
						ev[`APSO_ST_FRAME_DONE] = 1'b1;
					end
				end
			end
		endcase
		// the output follows the level, the status keeps only the rising edge
		// light error output
		next_st.light_prev  = light_s;
		next_st.light_error = light_s;
		if (light_s && !st.light_prev)
		begin
			ev[`APSO_ST_LIGHT_ERR] = 1'b1;
		end
		// register writes
		if (wr_ctrl)
		begin
			next_st.ctrl = wdata[`APSO_CTRL_W-1:0];
		end
		if (wr_mask)
		begin
			next_st.mask = wdata[`APSO_ST_W-1:0];
		end
		// sticky status, write one clears, a new event wins
		// a clear and an event in one cycle leave the bit set
		if (wr_status)
		begin
			next_st.status = st.status & ~wdata[`APSO_ST_W-1:0];
		end
		next_st.status = next_st.status | ev;
		// read data for the cycle after the strobe
		// zero in every other cycle, so a stale read never lingers
		next_st.rdata = '0;
		if (rd)
		begin
			unique case (addr)
				`APSO_ADDR_CTRL:     next_st.rdata = {29'h0, st.ctrl};
				`APSO_ADDR_STATUS:   next_st.rdata = {29'h0, st.status};
				`APSO_ADDR_MASK:     next_st.rdata = {29'h0, st.mask};
				`APSO_ADDR_POSITION: next_st.rdata = {19'h0, st.pos_snap};
				`APSO_ADDR_PINS:     next_st.rdata = {12'h0, st.pin_s2};
				default:             next_st.rdata = '0;
			endcase
		end
	end

	// state register
	// reset branch assigns constants only
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			// pins start at their idle levels, no false edge or mode change after reset
			st.pin_s1      <= `APSO_PIN_RESET;
			st.pin_s2      <= `APSO_PIN_RESET;
			st.sclk_prev   <= 1'b1;
			st.mode        <= APSO_MODE_LOAD;
			st.shreg       <= '0;
			st.bit_cnt     <= '0;
			st.ctrl        <= `APSO_CTRL_RESET;
			st.status      <= `APSO_STATUS_RESET;
			st.mask        <= `APSO_MASK_RESET;
			st.pos_snap    <= '0;
			st.light_prev  <= 1'b0;
			st.light_error <= 1'b0;
			st.rdata       <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// outputs
	// irq stays high until software clears or masks the bit
	// msb first
	assign serial_out  = st.shreg[`APSO_WORD_W-1];
	assign light_error = st.light_error;
	assign rdata       = st.rdata;
	assign irq         = |(st.status & st.mask);

endmodule // apso_top

// File: test/apso_monitor.sv
`timescale 1ns/10ps
module apso_monitor
(
	input wire logic        clock,            // system clock
	input wire logic        rst,              // async reset
	input wire logic [10:0] coarse_track,     // coarse tracks
	input wire logic        gray_correct_en,  // correction pin
	input wire logic        direction_invert, // msb invert pin
	input wire logic        load_shift_sel,   // 1 load, 0 shift
	input wire logic        shift_clk,        // link clock
	input wire logic        light_fault,      // light monitor
	input wire logic [7:0]  addr,             // bus address
	input wire logic        wr,               // write strobe
	input wire logic [31:0] wdata,            // write data
	input wire logic        rd,               // read strobe
	input wire logic [31:0] rdata,            // read data
	input wire logic        serial_out,       // serial data
	input wire logic        light_error,      // light error out
	input wire logic        irq               // interrupt
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic [7:0] sclk_hist;
	logic       recent_rise;
	logic       sw_override;
	// shadow of the software override bit
	always_ff @(posedge clock or posedge rst)
		if (rst)
			sw_override <= 1'b0;
		else if (wr && addr == 8'h00)
			sw_override <= wdata[0];
	// link clock history, idle high
	always_ff @(posedge clock or posedge rst)
		if (rst)
			sclk_hist <= 8'hff;
		else
			sclk_hist <= {sclk_hist[6:0], shift_clk};
	assign recent_rise = |(sclk_hist[6:0] & ~sclk_hist[7:1]);
	// steady load mode with correction off
	sequence load_steady;
		(load_shift_sel && !gray_correct_en && !sw_override
			&& $stable(coarse_track) && $stable(direction_invert)) [*8];
	endsequence
	// settled shift mode
	sequence shift_steady;
		!load_shift_sel [*8];
	endsequence
	reset_out_a: assert property ($fell(rst) |-> !serial_out && !irq && !light_error && rdata == 32'h0)
		else $error("outputs not cleared by reset");
	light_follow_a: assert property ($stable(light_fault) [*4] |-> light_error == light_fault)
		else $error("light error does not follow fault");
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data without read");
	unmapped_read_a: assert property (rd && addr > 8'h10 |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	field_width_a: assert property (rd && addr <= 8'h08 |=> rdata[31:3] == 29'h0)
		else $error("control bits above field");
	position_width_a: assert property (rd && addr == 8'h0c |=> rdata[31:13] == 19'h0)
		else $error("position wider than word");
	load_msb_a: assert property (load_steady |-> serial_out == (coarse_track[10] ^ direction_invert))
		else $error("load mode msb wrong");
	shift_edge_a: assert property (shift_steady ##0 $changed(serial_out) |-> recent_rise)
		else $error("shift without clock rise");
endmodule // apso_monitor
bind apso_top apso_monitor apso_monitor_inst (.clock(clock), .rst(rst), .coarse_track(coarse_track),
	.gray_correct_en(gray_correct_en), .direction_invert(direction_invert), .load_shift_sel(load_shift_sel),
	.shift_clk(shift_clk), .light_fault(light_fault), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd),
	.rdata(rdata), .serial_out(serial_out), .light_error(light_error), .irq(irq));

// File: test/apso_ssi_ctrl.sv
`timescale 1ns/10ps
module apso_ssi_ctrl
(
	input  wire logic clock,          // bench clock, paces the link
	output logic      shift_clk,      // link clock, idle high
	output logic      load_shift_sel, // 1 load, 0 shift
	output logic      serial_in,      // chain data, idle high
	input  wire logic serial_out      // encoder data
);
	// idle lines rest at pull-up level
	initial
	begin
		shift_clk = 1'b1;
		load_shift_sel = 1'b1;
		serial_in = 1'b1;
	end
	// one frame, din[i] fed during bit i, four clocks per half period
	task automatic read_frame(input int n, input logic [14:0] din, output logic [14:0] dout);
		dout = 15'h0;
		@(posedge clock);
		load_shift_sel <= 1'b0;
		repeat (10) @(posedge clock);
		for (int i = 0; i < n; i++)
		begin
			shift_clk <= 1'b0;
			serial_in <= din[i];
			repeat (4) @(posedge clock);
			dout = {dout[13:0], serial_out};
			shift_clk <= 1'b1;
			repeat (4) @(posedge clock);
		end
		serial_in <= 1'b1;
		load_shift_sel <= 1'b1;
		repeat (10) @(posedge clock);
	endtask
endmodule // apso_ssi_ctrl

// File: test/apso_top_tb_top.sv
`timescale 1ns/10ps
`include "apso_cfg.svh"
module apso_top_tb_top;
	logic        clock, rst, sine_track_bit, cosine_track_bit, interp_bit, gray_correct_en;
	logic        direction_invert, load_shift_sel, serial_in, shift_clk, light_fault, wr, rd;
	logic        serial_out, light_error, irq;
	logic [10:0] coarse_track;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	int          failures, checks;
	// cases: coarse, {sine, cos, interp, corr, inv}, word
	logic [10:0] tc [4] = '{11'h5a3, 11'h5a3, 11'h001, 11'h001};
	logic [4:0]  tp [4] = '{5'b10000, 5'b10001, 5'b00110, 5'b00100};
	logic [12:0] tw [4] = '{13'h168e, 13'h068e, 13'h000d, 13'h0005};
	apso_top apso_top_inst (.clock(clock), .rst(rst), .coarse_track(coarse_track),
		.sine_track_bit(sine_track_bit), .cosine_track_bit(cosine_track_bit), .interp_bit(interp_bit),
		.gray_correct_en(gray_correct_en), .direction_invert(direction_invert),
		.load_shift_sel(load_shift_sel), .serial_in(serial_in), .shift_clk(shift_clk),
		.light_fault(light_fault), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.serial_out(serial_out), .light_error(light_error), .irq(irq));
	apso_ssi_ctrl apso_ssi_ctrl_inst (.clock(clock), .shift_clk(shift_clk), .load_shift_sel(load_shift_sel),
		.serial_in(serial_in), .serial_out(serial_out));
	// 50 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask
	// reset values, write back, unmapped space
	task automatic t_regs();
		bus_rd(`APSO_ADDR_CTRL, 32'h0);
		bus_rd(`APSO_ADDR_STATUS, 32'h0);
		bus_rd(`APSO_ADDR_MASK, 32'h0);
		bus_rd(`APSO_ADDR_PINS, 32'h70000);
		bus_wr(`APSO_ADDR_CTRL, 32'h6);
		bus_rd(`APSO_ADDR_CTRL, 32'h6);
		bus_wr(8'h14, 32'hffffffff);
		bus_rd(8'h14, 32'h0);
		bus_wr(`APSO_ADDR_CTRL, 32'h0);
	endtask
	// full word then two chained bits
	task automatic t_frame(input int i);
		logic [14:0] dout;
		@(posedge clock);
		coarse_track <= tc[i];
		{sine_track_bit, cosine_track_bit, interp_bit, gray_correct_en, direction_invert} <= tp[i];
		idle(10);
		apso_ssi_ctrl_inst.read_frame(15, 15'h0002, dout);
		check({17'h0, dout}, {17'h0, tw[i], 2'b01});
		bus_rd(`APSO_ADDR_POSITION, {19'h0, tw[i]});
	endtask
	// software override: pins ask for no inversion, control forces it
	task automatic t_override();
		logic [14:0] dout;
		bus_wr(`APSO_ADDR_CTRL, 32'h5);
		@(posedge clock);
		coarse_track <= tc[0];
		{sine_track_bit, cosine_track_bit, interp_bit, gray_correct_en, direction_invert} <= tp[0];
		idle(10);
		apso_ssi_ctrl_inst.read_frame(15, 15'h0002, dout);
		check({17'h0, dout}, {17'h0, tw[1], 2'b01});
		bus_wr(`APSO_ADDR_CTRL, 32'h0);
		idle(10);
	endtask
	// sticky events, mask, write-one clear
	task automatic t_irq();
		bus_rd(`APSO_ADDR_STATUS, 32'h3);
		check({31'h0, irq}, 32'h0);
		bus_wr(`APSO_ADDR_MASK, 32'h1);
		idle(3);
		check({31'h0, irq}, 32'h1);
		bus_wr(`APSO_ADDR_STATUS, 32'h1);
		light_fault <= 1'b1;
		idle(4);
		check({31'h0, irq}, 32'h0);
		check({31'h0, light_error}, 32'h1);
		bus_rd(`APSO_ADDR_STATUS, 32'h6);
		bus_wr(`APSO_ADDR_MASK, 32'h4);
		light_fault <= 1'b0;
		idle(4);
		check({31'h0, irq}, 32'h1);
		bus_wr(`APSO_ADDR_STATUS, 32'h7);
		idle(3);
		check({30'h0, irq, light_error}, 32'h0);
	endtask
	task automatic final_report();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// main sequence
	initial
	begin
		rst = 1'b1;
		{coarse_track, sine_track_bit, cosine_track_bit, interp_bit} = 14'h0;
		{gray_correct_en, direction_invert, light_fault, wr, rd} = 5'h0;
		addr = 8'h0;
		wdata = 32'h0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		t_regs();
		for (int i = 0; i < 4; i++)
			t_frame(i);
		t_override();
		t_irq();
		final_report();
	end
	// cut a hung run short
	initial
	begin
		#200000;
		failures++;
		final_report();
	end
endmodule // apso_top_tb_top
